// ---- hw/boir_decode.v ----
// Decoder for the two-word block output encoding
`timescale 1ns/1ps
`include "boir_map.vh"
module boir_decode (
   input wire [15:0] word1,
   input wire [15:0] word2,
   output wire match,
   output wire isByte,
   output wire [3:0] srcReg,
   output wire [3:0] cntReg,
   output wire [3:0] dstReg
);
   assign match = (word1[15:9] == `BOIR_OP1_HI) && (word1[3:0] == `BOIR_OP1_LO) &&
                  (word2[15:12] == `BOIR_OP2_HI) && (word2[3:0] == `BOIR_OP2_LO); // [RULE_11]
   assign isByte = ~word1[8];
   assign srcReg = word1[7:4];
   assign cntReg = word2[11:8];
   assign dstReg = word2[7:4];
endmodule // boir_decode

// ---- hw/boir_fifo.v ----
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module boir_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_sys,
   input wire reset,
   input wire [WIDTH-1:0] inData,
   input wire inValid,
   output wire inReady,
   output wire [WIDTH-1:0] outData,
   output wire outValid,
   input wire outReady
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_q;
   reg [AW-1:0] rdPtr_q;
   reg [AW:0] count_q;
   wire doWr;
   wire doRd;
   localparam [AW:0] DEPTH_W = DEPTH;
   assign inReady = (count_q != DEPTH_W);
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign outData = mem[rdPtr_q];
   assign doWr = inValid & inReady;
   assign doRd = outValid & outReady;
   always @(posedge clk_sys) begin
      if (doWr) begin
         mem[wrPtr_q] <= inData;
      end
      if (reset) begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (doWr) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (doRd) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         count_q <= count_q + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
      end
   end
endmodule // boir_fifo

// ---- hw/boir_seq.v ----
// Sequencer for the repeating block output instruction
// ==========================================================
// How it works
// [RULE_01] Read memory at source, write to port
// [RULE_02] Port address 16 bits, fixed whole transfer
// [RULE_03] Source pointer plus one byte, two word
// [RULE_04] Counter minus one, repeat until zero
// [RULE_05] Software loads count within legal range
// [RULE_06] Eleven cycles plus ten per element
// [RULE_07] Executes only in privileged state
// [RULE_08] Interrupt accepted after each element; the code does not sample irqReq after the last element
// [RULE_09] Save instruction start PC before interrupt
// [RULE_10] Seven extra cycles per accepted interrupt
// [RULE_11] Two-word encoding decoded
// [RULE_12] Overflow set, other flags kept
// [RULE_13] Unprivileged fetch traps, no transfer
`timescale 1ns/1ps
`include "boir_map.vh"
module boir_seq #(
   parameter FIFO_DEPTH = `BOIR_FIFO_DEPTH
) (
   input wire clk_sys,
   input wire reset,
   // Instruction issue
   input wire start,
   input wire [15:0] instWord1,
   input wire [15:0] instWord2,
   input wire [15:0] instPc,
   input wire privMode,
   input wire [7:0] flagsIn,
   // Register file read values
   input wire [15:0] srcValue,
   input wire [15:0] cntValue,
   input wire [15:0] dstValue,
   // Memory read
   input wire memAck,
   input wire [15:0] memRdData,
   // I/O write
   input wire ioAck,
   // Interrupt
   input wire irqReq,
   output reg busy,
   output reg done,
   output reg trap,
   output reg illegal,
   output reg [3:0] srcSel,
   output reg [3:0] cntSel,
   output reg [3:0] dstSel,
   output reg regWe,
   output reg [3:0] regWrSel,
   output reg [15:0] regWrData,
   output reg memRd,
   output reg [15:0] memAddr,
   output reg memByte,
   output reg ioWr,
   output reg [15:0] ioAddr,
   output reg [15:0] ioData,
   output reg ioByte,
   output reg irqTake,
   output reg [15:0] savedPc,
   output reg flagsWe,
   output reg [7:0] flagsOut
);
   // ==========================================================
   // State codes and timing loads
   localparam S_IDLE = 3'd0;
   localparam S_SETUP = 3'd1;
   localparam S_ELEM = 3'd2;
   localparam S_IRQ = 3'd3;
   localparam S_FINISH = 3'd4;
   localparam FIFO_AW = 4;
   localparam [5:0] SETUP_CYC = `BOIR_SETUP_CYC;
   localparam [5:0] ELEM_CYC = `BOIR_ELEM_CYC;
   localparam [5:0] IRQ_CYC = `BOIR_IRQ_CYC;
   // Start cycle counts as the first setup cycle
   localparam [5:0] SETUP_LOAD = SETUP_CYC - 6'd2;

   // ==========================================================
   // Registers and wires
   wire decMatch;
   wire decByte;
   wire [3:0] decSrc;
   wire [3:0] decCnt;
   wire [3:0] decDst;
   reg [2:0] state_q;
   reg [5:0] tick_q;
   reg [15:0] src_q;
   reg [15:0] cnt_q;
   reg [15:0] port_q;
   reg byte_q;
   reg [15:0] pc_q;
   reg memPend_q;
   reg elemRead_q;
   reg elemSent_q;
   reg fifoSent_q;
   wire fifoInReady;
   wire fifoOutValid;
   wire [15:0] fifoOutData;
   wire fifoPush;
   wire fifoPop;
   wire [15:0] cntNext;
   wire [15:0] srcStep;
   wire [15:0] srcNext;
   wire lastElem;
   wire [7:0] flagsDone;

   // ==========================================================
   // Instruction decode
   boir_decode u_decode (
      .word1(instWord1),
      .word2(instWord2),
      .match(decMatch),
      .isByte(decByte),
      .srcReg(decSrc),
      .cntReg(decCnt),
      .dstReg(decDst)
   );

   // ==========================================================
   // Data path buffer between memory read and port write
   // One element in flight; spare depth is headroom
   assign fifoPush = memRd & memAck & fifoInReady;
   assign fifoPop = ioWr & ioAck;
   boir_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .inData(memRdData),
      .inValid(memRd & memAck),
      .inReady(fifoInReady),
      .outData(fifoOutData),
      .outValid(fifoOutValid),
      .outReady(fifoPop)
   );

   // ==========================================================
   // Per-element arithmetic
   assign cntNext = cnt_q - 16'h0001;
   assign srcStep = byte_q ? 16'h0001 : 16'h0002;
   assign srcNext = src_q + srcStep;
   assign lastElem = (cntNext == 16'h0000);
   assign flagsDone = flagsIn | (8'h01 << `BOIR_FLAG_V);


   // ==========================================================
   // Sequencer
   // Idle, setup, elements, then finish or interrupt tail
   always @(posedge clk_sys) begin
      if (reset) begin
         state_q <= S_IDLE;
         tick_q <= 6'h00;
         src_q <= 16'h0000;
         cnt_q <= 16'h0000;
         port_q <= 16'h0000;
         byte_q <= 1'b0;
         pc_q <= 16'h0000;
         memPend_q <= 1'b0;
         elemRead_q <= 1'b0;
         elemSent_q <= 1'b0;
         fifoSent_q <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         trap <= 1'b0;
         illegal <= 1'b0;
         srcSel <= 4'h0;
         cntSel <= 4'h0;
         dstSel <= 4'h0;
         regWe <= 1'b0;
         regWrSel <= 4'h0;
         regWrData <= 16'h0000;
         memRd <= 1'b0;
         memAddr <= 16'h0000;
         memByte <= 1'b0;
         ioWr <= 1'b0;
         ioAddr <= 16'h0000;
         ioData <= 16'h0000;
         ioByte <= 1'b0;
         irqTake <= 1'b0;
         savedPc <= 16'h0000;
         flagsWe <= 1'b0;
         flagsOut <= 8'h00;
      end else begin
         done <= 1'b0;
         trap <= 1'b0;
         illegal <= 1'b0;
         regWe <= 1'b0;
         irqTake <= 1'b0;
         flagsWe <= 1'b0;
         if (fifoPush) begin
            memRd <= 1'b0;
            elemRead_q <= 1'b1;
         end
         if (fifoPop) begin
            ioWr <= 1'b0;
            elemSent_q <= 1'b1;
         end
         case (state_q)
            S_IDLE: begin
               busy <= 1'b0;
               if (start) begin
                  srcSel <= decSrc;
                  cntSel <= decCnt;
                  dstSel <= decDst;
                  if (!decMatch) begin
                     illegal <= 1'b1;
                  end else if (!privMode) begin
                     trap <= 1'b1; // [RULE_07] [RULE_13]
                  end else begin
                     busy <= 1'b1;
                     byte_q <= decByte;
                     pc_q <= instPc;
                     tick_q <= SETUP_LOAD; // [RULE_06]
                     state_q <= S_SETUP;
                  end
               end
            end
            S_SETUP: begin
               // Operands latched from the register file once selects settle
               if (tick_q == 6'd1) begin
                  src_q <= srcValue;
                  cnt_q <= cntValue; // [RULE_05]
                  port_q <= dstValue; // [RULE_02]
               end
               if (tick_q == 6'd0) begin
                  state_q <= S_ELEM;
                  tick_q <= ELEM_CYC - 6'd1;
                  memRd <= 1'b1; // [RULE_01]
                  memAddr <= src_q;
                  memByte <= byte_q;
                  elemRead_q <= 1'b0;
                  elemSent_q <= 1'b0;
                  fifoSent_q <= 1'b0;
               end else begin
                  tick_q <= tick_q - 6'd1;
               end
            end
            S_ELEM: begin
               if (elemRead_q && fifoOutValid && !fifoSent_q) begin
                  ioWr <= 1'b1; // [RULE_01]
                  ioAddr <= port_q; // [RULE_02]
                  ioData <= fifoOutData;
                  ioByte <= byte_q;
                  fifoSent_q <= 1'b1;
               end
               if (tick_q != 6'd0) begin
                  tick_q <= tick_q - 6'd1;
               end else if (elemSent_q) begin
                  // Element cost is ten cycles unless the buses stall
                  src_q <= srcNext; // [RULE_03]
                  cnt_q <= cntNext; // [RULE_04]
                  regWe <= 1'b1;
                  regWrSel <= cntSel;
                  regWrData <= cntNext;
                  if (lastElem) begin
                     state_q <= S_FINISH; // [RULE_04] [RULE_06]
                  end else if (irqReq) begin
                     savedPc <= pc_q; // [RULE_09]
                     // Tail runs one cycle past its count, like the finish cycle
                     tick_q <= IRQ_CYC; // [RULE_10]
                     state_q <= S_IRQ; // [RULE_08]
                  end else begin
                     tick_q <= ELEM_CYC - 6'd1;
                     memRd <= 1'b1;
                     memAddr <= srcNext;
                     elemRead_q <= 1'b0;
                     elemSent_q <= 1'b0;
                     fifoSent_q <= 1'b0;
                  end
               end
            end
            S_IRQ: begin
               // Source pointer written back so the restart resumes here
               if (tick_q == IRQ_CYC) begin
                  regWe <= 1'b1;
                  regWrSel <= srcSel; // [RULE_09]
                  regWrData <= src_q;
               end
               if (tick_q == 6'd0) begin
                  irqTake <= 1'b1; // [RULE_08]
                  busy <= 1'b0;
                  state_q <= S_IDLE;
               end else begin
                  tick_q <= tick_q - 6'd1;
               end
            end
            S_FINISH: begin
               // Source pointer written back once at the end
               regWe <= 1'b1;
               regWrSel <= srcSel;
               regWrData <= src_q;
               flagsWe <= 1'b1;
               flagsOut <= flagsDone; // [RULE_12]
               done <= 1'b1;
               busy <= 1'b0;
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // boir_seq

// ---- pkg/boir_map.vh ----
// Constants for the block output, increment and repeat sequencer
`ifndef BOIR_MAP_VH
`define BOIR_MAP_VH
`define BOIR_OP1_HI 7'h1D
`define BOIR_OP1_LO 4'h2
`define BOIR_OP2_HI 4'h0
`define BOIR_OP2_LO 4'h0
`define BOIR_SETUP_CYC 11
`define BOIR_ELEM_CYC 10
`define BOIR_IRQ_CYC 7
`define BOIR_FIFO_DEPTH 16
`define BOIR_FLAG_V 4
`endif

// ---- tb/block_output_increment_repeat_test.sv ----
// Testbench for the repeating block output sequencer
`timescale 1ns/1ps
module block_output_increment_repeat_test;
   reg clk_sys = 1'b0, reset = 1'b1, start = 1'b0, privMode = 1'b0, irqReq = 1'b0;
   reg [15:0] instWord1 = 16'h0000, instWord2 = 16'h0310, instPc = 16'h0400;
   reg [7:0] flagsIn = 8'h21, stall = 8'h00;
   reg [15:0] regs [0:15];
   integer miscompares = 0, checks_done = 0, cyc = 0, t0, i, wrBase = 0;
   wire busy, done, trap, illegal, regWe, memRd, memByte, ioWr, ioByte, irqTake, flagsWe, ioAck;
   wire [3:0] srcSel, cntSel, dstSel, regWrSel;
   wire [15:0] regWrData, memAddr, ioAddr, ioData, savedPc;
   wire [7:0] flagsOut;
   wire memAck = memRd;
   wire [15:0] memRdData = memVal(memAddr);
   wire [15:0] srcValue = regs[srcSel], cntValue = regs[cntSel], dstValue = regs[dstSel];
   function [15:0] memVal(input [15:0] a);
      memVal = {a[15:8], ~a[7:0]};
   endfunction
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (regWe) regs[regWrSel] <= regWrData;
   end
   boir_seq dut (
      .clk_sys(clk_sys), .reset(reset), .start(start), .instWord1(instWord1), .instWord2(instWord2),
      .instPc(instPc), .privMode(privMode), .flagsIn(flagsIn), .srcValue(srcValue), .cntValue(cntValue),
      .dstValue(dstValue), .memAck(memAck), .memRdData(memRdData), .ioAck(ioAck), .irqReq(irqReq),
      .busy(busy), .done(done), .trap(trap), .illegal(illegal), .srcSel(srcSel), .cntSel(cntSel),
      .dstSel(dstSel), .regWe(regWe), .regWrSel(regWrSel), .regWrData(regWrData), .memRd(memRd),
      .memAddr(memAddr), .memByte(memByte), .ioWr(ioWr), .ioAddr(ioAddr), .ioData(ioData),
      .ioByte(ioByte), .irqTake(irqTake), .savedPc(savedPc), .flagsWe(flagsWe), .flagsOut(flagsOut)
   );
   boir_io_periph u_periph (
      .clk_sys(clk_sys), .reset(reset), .ioWr(ioWr), .ioAddr(ioAddr), .ioData(ioData),
      .ioByte(ioByte), .stall(stall), .ioAck(ioAck)
   );
   // ==========================================
   // Shared tasks
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task setRegs(input [15:0] src, input [15:0] n);
      begin
         regs[1] = 16'h0FFF;
         regs[2] = src;
         regs[3] = n;
         wrBase = u_periph.nWr;
      end
   endtask
   task issue(input [15:0] w1, input pr);
      begin
         @(negedge clk_sys);
         instWord1 = w1;
         privMode = pr;
         start = 1'b1;
         @(negedge clk_sys);
         start = 1'b0;
         t0 = cyc;
      end
   endtask
   task waitEnd;
      for (i = 0; i < 2000 && done !== 1'b1 && irqTake !== 1'b1; i = i + 1) @(negedge clk_sys);
   endtask
   task verify(input [15:0] src, input [15:0] n, input [15:0] mask, input [15:0] step);
      integer k;
      begin
         chk(u_periph.nWr - wrBase, n);
         for (k = 0; k < n; k = k + 1) begin
            chk(u_periph.logData[(wrBase + k) % 8] & mask, memVal(src + k * step) & mask);
            chk(u_periph.logAddr[(wrBase + k) % 8], 16'h0FFF);
         end
         chk(regs[2], src + n * step);
         chk(regs[3], 16'h0000);
      end
   endtask
   // ==========================================
   // Scenarios
   task t_word;
      begin
         setRegs(16'h1000, 3);
         issue(16'h3B22, 1'b1);
         repeat (3) @(negedge clk_sys);
         start = 1'b1;
         @(negedge clk_sys);
         start = 1'b0;
         waitEnd;
         chk(cyc - t0, 11 + 10 * 3);
         chk(flagsOut, 8'h31);
         @(negedge clk_sys);
         verify(16'h1000, 3, 16'hFFFF, 2);
         $display("word transfer done");
      end
   endtask
   task t_byte;
      begin
         setRegs(16'h3001, 2);
         stall = 8'h03;
         issue(16'h3A22, 1'b1);
         waitEnd;
         @(negedge clk_sys);
         stall = 8'h00;
         verify(16'h3001, 2, 16'h00FF, 1);
         $display("byte transfer done");
      end
   endtask
   task t_irq;
      begin
         setRegs(16'h2000, 3);
         irqReq = 1'b1;
         instPc = 16'h0520;
         issue(16'h3B22, 1'b1);
         waitEnd;
         chk(cyc - t0, 11 + 10 + 7);
         chk(savedPc, 16'h0520);
         irqReq = 1'b0;
         @(negedge clk_sys);
         chk(regs[2], 16'h2002);
         chk(regs[3], 16'h0002);
         issue(16'h3B22, 1'b1);
         waitEnd;
         chk(cyc - t0, 11 + 10 * 2);
         @(negedge clk_sys);
         verify(16'h2000, 3, 16'hFFFF, 2);
         $display("interrupt resume done");
      end
   endtask
   task t_refuse;
      begin
         setRegs(16'h4000, 2);
         issue(16'h3B22, 1'b0);
         chk({15'h0000, trap}, 16'h0001);
         repeat (40) @(negedge clk_sys);
         chk(u_periph.nWr - wrBase, 0);
         issue(16'h3B2A, 1'b1);
         chk({15'h0000, illegal}, 16'h0001);
         repeat (40) @(negedge clk_sys);
         chk(u_periph.nWr - wrBase, 0);
         $display("refusal done");
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", checks_done, miscompares);
         if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      for (i = 0; i < 16; i = i + 1) regs[i] = 16'h0000;
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'b0;
      t_word;
      t_byte;
      t_irq;
      t_refuse;
      final_report;
   end
   initial begin
      #20000;
      miscompares = miscompares + 1;
      final_report;
   end
endmodule // block_output_increment_repeat_test

// ---- tb/boir_io_periph.sv ----
// Port peripheral model that accepts writes after a set delay
`timescale 1ns/1ps
module boir_io_periph (
   input wire clk_sys,
   input wire reset,
   input wire ioWr,
   input wire [15:0] ioAddr,
   input wire [15:0] ioData,
   input wire ioByte,
   input wire [7:0] stall,
   output reg ioAck
);
   reg [7:0] waitQ = 8'h00;
   reg [15:0] logData [0:7];
   reg [15:0] logAddr [0:7];
   integer nWr = 0;
   initial ioAck = 1'b0;
   // ==========================================
   // Ack after stall cycles, log each write
   always @(negedge clk_sys) begin
      if (!reset && ioWr && !ioAck && waitQ >= stall) begin
         ioAck <= 1'b1;
         waitQ <= 8'h00;
      end else begin
         ioAck <= 1'b0;
         waitQ <= ioWr ? waitQ + 8'h01 : 8'h00;
      end
   end
   always @(posedge clk_sys) begin
      if (ioWr && ioAck) begin
         logData[nWr[2:0]] <= ioByte ? {8'h00, ioData[7:0]} : ioData;
         logAddr[nWr[2:0]] <= ioAddr;
         nWr <= nWr + 1;
      end
   end
endmodule // boir_io_periph

// ---- tb/boir_seq_sva.sv ----
// Assertion checker for the block output sequencer
`timescale 1ns/1ps
`include "boir_map.vh"
module boir_seq_sva (
   input wire clk_sys,
   input wire reset,
   input wire start,
   input wire [15:0] instWord1,
   input wire [15:0] instWord2,
   input wire [15:0] instPc,
   input wire privMode,
   input wire [7:0] flagsIn,
   input wire memAck,
   input wire [15:0] memRdData,
   input wire ioAck,
   input wire busy,
   input wire trap,
   input wire illegal,
   input wire memRd,
   input wire [15:0] memAddr,
   input wire memByte,
   input wire ioWr,
   input wire [15:0] ioAddr,
   input wire [15:0] ioData,
   input wire ioByte,
   input wire irqTake,
   input wire [15:0] savedPc,
   input wire flagsWe,
   input wire [7:0] flagsOut
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire okOp = instWord1[15:9] == `BOIR_OP1_HI && instWord1[3:0] == `BOIR_OP1_LO &&
               instWord2[15:12] == `BOIR_OP2_HI && instWord2[3:0] == `BOIR_OP2_LO;
   wire go = start && !busy;
   reg [15:0] pcQ, dataQ, lastQ, portQ;
   reg haveQ, portQSet;
   // ==========================================
   // Helper state per instruction
   always @(posedge clk_sys) begin
      if (reset || go) begin
         haveQ <= 1'b0;
         portQSet <= 1'b0;
         pcQ <= instPc;
      end else begin
         if (memRd && memAck) begin
            dataQ <= memRdData;
            lastQ <= memAddr;
            haveQ <= 1'b1;
         end
         if (ioWr) begin
            portQ <= ioAddr;
            portQSet <= 1'b1;
         end
      end
   end
   a_setup_len: assert property (go && privMode && okOp |-> ##11 memRd) else $error("setup length wrong");
   a_unpriv_trap: assert property (go && !privMode && okOp |=> trap && !busy) else $error("no trap");
   a_bad_code: assert property (go && privMode && instWord1[3:0] != `BOIR_OP1_LO |=> illegal && !busy)
      else $error("bad code taken");
   a_io_hold: assert property (ioWr && !ioAck |=> ioWr && $stable(ioData) && $stable(ioAddr))
      else $error("port write dropped");
   a_io_data: assert property (ioWr |-> (ioByte ? ioData[7:0] == dataQ[7:0] : ioData == dataQ))
      else $error("port data wrong");
   a_port_fixed: assert property (ioWr && portQSet |-> ioAddr == portQ) else $error("port moved");
   a_src_step: assert property ($rose(memRd) && haveQ |-> memAddr == lastQ + (memByte ? 16'h0001 : 16'h0002))
      else $error("source step wrong");
   a_flag_v: assert property (flagsWe |-> flagsOut == (flagsIn | (8'h01 << `BOIR_FLAG_V)))
      else $error("flags wrong");
   a_pc_saved: assert property (irqTake |-> savedPc == pcQ) else $error("saved pc wrong");
   c_run: cover property (go && privMode && okOp);
   c_irq: cover property (irqTake);
   c_trap: cover property (trap);
   c_stall: cover property (ioWr && !ioAck);
endmodule // boir_seq_sva
bind boir_seq boir_seq_sva u_sva (
   .clk_sys(clk_sys), .reset(reset), .start(start), .instWord1(instWord1), .instWord2(instWord2),
   .instPc(instPc), .privMode(privMode), .flagsIn(flagsIn), .memAck(memAck), .memRdData(memRdData),
   .ioAck(ioAck), .busy(busy), .trap(trap), .illegal(illegal), .memRd(memRd), .memAddr(memAddr),
   .memByte(memByte), .ioWr(ioWr), .ioAddr(ioAddr), .ioData(ioData), .ioByte(ioByte),
   .irqTake(irqTake), .savedPc(savedPc), .flagsWe(flagsWe), .flagsOut(flagsOut)
);
